/* design/burst_flash_pins.sv */
/*
 * Pin-level behaviour of a burst-mode flash: address latch, burst counter,
 * ready, hardware reset, write protect and program acceleration.
 * Assumes all pins come from the host asynchronously; the host clock is a
 * sampled input, much slower than the reference clock.
 */
`timescale 1ns/1ps
`include "burst_flash_regs.svh"
module burst_flash_pins
    import burst_flash_pkg::*;
#(
    parameter int ADDR_W    = 23,
    parameter int MEM_AW    = 8,
    parameter int SEC_SHIFT = 14,
    parameter int PROT_SEC  = 257
) (
    input  wire logic        REF_CLK_I,
    input  wire logic        RSTN_I,
    input  wire logic        FCLK_I,
    input  wire logic        ADDRESS_VALID_N_I,
    input  wire logic        CE_N_I,
    input  wire logic        OE_N_I,
    input  wire logic        WE_N_I,
    input  wire logic        HW_RESET_N_I,
    input  wire logic        WP_N_I,
    input  wire logic        BURST_CFG_I,
    input  wire logic [1:0]  PROGRAM_ACCEL_INPUT_I,
    input  wire logic [6:0]  A_HI_I,
    input  wire logic [15:0] ADQ_I,
    output logic      [15:0] ADQ_O,
    output logic             ADQ_OE_O,
    output logic             RDY_O,
    output logic             UNLOCK_BYPASS_O,
    output logic             PROG_REFUSED_O
);
    localparam int SEC_W    = ADDR_W - SEC_SHIFT;
    localparam int PROG_CYC = (`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam int ACCEL_CYC = (`ACCEL_PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

    // Refuse parameter sets the logic cannot serve
    if (ADDR_W != 23 || MEM_AW < 1 || MEM_AW > ADDR_W || SEC_SHIFT >= ADDR_W
        || PROT_SEC + 1 >= (1 << SEC_W) || PROG_CYC > 255) begin : g_bad_params
        $error("burst_flash_pins: unsupported parameters");
    end

    // Three-stage pin sampling, change taken when stages two and three agree
    logic [`SYNC_W-1:0] s1_r, s2_r, s3_r, filt_r, filt_nxt;
    logic [`SYNC_W-1:0] pins;

    assign pins = {ADQ_I, A_HI_I, PROGRAM_ACCEL_INPUT_I, BURST_CFG_I, WP_N_I,
                   HW_RESET_N_I, WE_N_I, OE_N_I, CE_N_I, ADDRESS_VALID_N_I, FCLK_I};

    always_comb begin
        filt_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & filt_r);
    end

    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            s1_r   <= `SYNC_RST;
            s2_r   <= `SYNC_RST;
            s3_r   <= `SYNC_RST;
            filt_r <= `SYNC_RST;
        end else begin
            s1_r   <= pins;
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            filt_r <= filt_nxt;
        end
    end

    logic              fclk, address_valid_n, ce_n, oe_n, we_n, rst_pin_n, wp_n, burst_cfg;
    accel_t            accel;
    logic [ADDR_W-1:0] pin_addr;
    logic [15:0]       pin_data;

    assign fclk            = filt_r[`PIN_FCLK];
    assign address_valid_n = filt_r[`PIN_ADDRESS_VALID_N];
    assign ce_n            = filt_r[`PIN_CE_N];
    assign oe_n            = filt_r[`PIN_OE_N];
    assign we_n            = filt_r[`PIN_WE_N];
    assign rst_pin_n       = filt_r[`PIN_RST_N];
    assign wp_n            = filt_r[`PIN_WP_N];
    assign burst_cfg       = filt_r[`PIN_BURST_CFG];
    assign accel           = accel_t'(filt_r[`PIN_ACCEL_LO +: 2]);
    assign pin_data        = filt_r[`PIN_ADQ_LO +: 16];
    assign pin_addr        = {filt_r[`PIN_AHI_LO +: 7], pin_data};

    // Control state
    flash_state_t      state_r, state_nxt;
    logic              burst_mode_r, burst_mode_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [1:0]        settle_r, settle_nxt;
    logic [7:0]        cnt_r, cnt_nxt;
    logic              fclk_prev_r, we_prev_r;
    logic [15:0]       dout_nxt;
    logic              oe_nxt, rdy_nxt, refused_nxt, bypass_nxt, mem_we;
    logic [15:0]       mem_rdata;
    logic              fclk_rise, we_fall, prot_hit, prog_ok;

    assign fclk_rise = fclk & ~fclk_prev_r;
    assign we_fall   = ~we_n & we_prev_r;
    assign prot_hit  = (addr_r[ADDR_W-1:SEC_SHIFT] == SEC_W'(PROT_SEC))
                     || (addr_r[ADDR_W-1:SEC_SHIFT] == SEC_W'(PROT_SEC + 1));
    assign prog_ok   = (accel != ACCEL_LOW) && !(!wp_n && prot_hit);

    always_comb begin
        state_nxt      = state_r;
        burst_mode_nxt = burst_mode_r;
        addr_nxt       = addr_r;
        settle_nxt     = (settle_r != 2'h0) ? settle_r - 2'h1 : settle_r;
        cnt_nxt        = cnt_r;
        mem_we         = 1'b0;
        refused_nxt    = 1'b0;
        if (!rst_pin_n) begin
            // Abort everything, back to asynchronous array read
            state_nxt      = ST_IDLE;
            burst_mode_nxt = 1'b0;
            settle_nxt     = 2'h0;
            cnt_nxt        = 8'h00;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (burst_cfg) begin
                        burst_mode_nxt = 1'b1;
                    end
                    if (!ce_n && !address_valid_n) begin
                        if (!burst_mode_r) begin
                            // Clock ignored in async mode
                            addr_nxt = pin_addr;
                        end else if (fclk_rise) begin
                            addr_nxt   = pin_addr;
                            state_nxt  = ST_BURST;
                            settle_nxt = `SETTLE_LOAD;
                        end
                    end else if (!ce_n && we_fall) begin
                        if (prog_ok) begin
                            mem_we    = 1'b1;
                            state_nxt = ST_PROG;
                            cnt_nxt   = (accel == ACCEL_HV) ? 8'(ACCEL_CYC) : 8'(PROG_CYC);
                        end else begin
                            refused_nxt = 1'b1;
                        end
                    end
                end
                ST_BURST: begin
                    if (ce_n) begin
                        state_nxt = ST_IDLE;
                    end else if (!address_valid_n && fclk_rise) begin
                        addr_nxt   = pin_addr;
                        settle_nxt = `SETTLE_LOAD;
                    end else if (fclk_rise && RDY_O) begin
                        addr_nxt   = addr_r + ADDR_W'(1);
                        settle_nxt = `SETTLE_LOAD;
                    end
                end
                ST_PROG: begin
                    cnt_nxt = cnt_r - 8'h01;
                    if (cnt_r == 8'h01) begin
                        state_nxt = ST_IDLE;
                    end
                end
                default: begin
                    state_nxt = ST_IDLE;
                end
            endcase
        end
        rdy_nxt  = (state_nxt == ST_BURST) && (settle_nxt == 2'h0);
        oe_nxt   = rdy_nxt || (rst_pin_n && state_nxt == ST_IDLE && !ce_n && !oe_n
                   && address_valid_n);
        dout_nxt = mem_rdata;
        bypass_nxt = (accel == ACCEL_HV);
    end

    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state_r         <= ST_IDLE;
            burst_mode_r    <= 1'b0;
            addr_r          <= '0;
            settle_r        <= 2'h0;
            cnt_r           <= 8'h00;
            fclk_prev_r     <= 1'b0;
            we_prev_r       <= 1'b0;
            ADQ_O           <= 16'h0000;
            ADQ_OE_O        <= 1'b0;
            RDY_O           <= 1'b0;
            UNLOCK_BYPASS_O <= 1'b0;
            PROG_REFUSED_O  <= 1'b0;
        end else begin
            state_r         <= state_nxt;
            burst_mode_r    <= burst_mode_nxt;
            addr_r          <= addr_nxt;
            settle_r        <= settle_nxt;
            cnt_r           <= cnt_nxt;
            fclk_prev_r     <= fclk;
            we_prev_r       <= we_n;
            ADQ_O           <= dout_nxt;
            ADQ_OE_O        <= oe_nxt;
            RDY_O           <= rdy_nxt;
            UNLOCK_BYPASS_O <= bypass_nxt;
            PROG_REFUSED_O  <= refused_nxt;
        end
    end

    flash_cells #(
        .AW (MEM_AW),
        .DW (16)
    ) u_cells (
        .clk_i   (REF_CLK_I),
        .we_i    (mem_we),
        .waddr_i (addr_r[MEM_AW-1:0]),
        .wdata_i (pin_data),
        .raddr_i (addr_r[MEM_AW-1:0]),
        .rdata_o (mem_rdata)
    );

    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RSTN_I);

    a_burst_latch: assert property (rst_pin_n && state_r == ST_IDLE && burst_mode_r
        && !ce_n && !address_valid_n && fclk_rise
        |=> state_r == ST_BURST && addr_r == $past(pin_addr))
        else $error("burst start did not latch address");
    a_burst_advance: assert property (rst_pin_n && state_r == ST_BURST && !ce_n
        && address_valid_n && fclk_rise && RDY_O |=> addr_r == $past(addr_r) + ADDR_W'(1))
        else $error("burst counter did not advance");
    a_async_capture: assert property (rst_pin_n && state_r == ST_IDLE && !burst_mode_r
        && !ce_n && !address_valid_n |=> addr_r == $past(pin_addr))
        else $error("async address not captured");
    a_addr_ignore: assert property (address_valid_n
        && !(state_r == ST_BURST && fclk_rise) |=> $stable(addr_r))
        else $error("address changed while address valid high");
    a_rdy_settle: assert property (rst_pin_n && state_r == ST_BURST && !ce_n && fclk_rise
        && RDY_O |=> !RDY_O [*2] ##1 (RDY_O || state_r != ST_BURST || !rst_pin_n || ce_n))
        else $error("ready not low while next word settles");
    a_rdy_drives: assert property (RDY_O |-> ADQ_OE_O && state_r == ST_BURST)
        else $error("ready without driven burst data");
    a_hw_reset: assert property (!rst_pin_n |=> state_r == ST_IDLE && !RDY_O
        && !burst_mode_r)
        else $error("hardware reset did not abort");
    a_wp_block: assert property (mem_we |-> !(!wp_n && prot_hit))
        else $error("write reached protected sector");
    a_accel_low: assert property (accel == ACCEL_LOW |-> !mem_we)
        else $error("program with accel low");
    a_accel_time: assert property (mem_we && accel == ACCEL_HV
        |=> cnt_r == 8'(ACCEL_CYC))
        else $error("accelerated program time wrong");
endmodule : burst_flash_pins

/* pkg/burst_flash_regs.svh */
/*
 * Constants for the burst flash pin block: pin vector positions, timing.
 * Assumes a 20 MHz reference clock inside the device.
 */
`ifndef BURST_FLASH_REGS_SVH
`define BURST_FLASH_REGS_SVH

`define CLK_PERIOD_NS      50
`define PROG_TIME_NS       2000
`define ACCEL_PROG_TIME_NS 1000

`define PIN_FCLK          0
`define PIN_ADDRESS_VALID_N 1
`define PIN_CE_N          2
`define PIN_OE_N          3
`define PIN_WE_N          4
`define PIN_RST_N         5
`define PIN_WP_N          6
`define PIN_BURST_CFG     7
`define PIN_ACCEL_LO      8
`define PIN_AHI_LO        10
`define PIN_ADQ_LO        17
`define SYNC_W            33
`define SYNC_RST          33'h0_0000_0000
`define SETTLE_LOAD       2'h2

`endif

/* pkg/burst_flash_pkg.sv */
/*
 * Types for the burst flash pin block.
 * Assumes nothing beyond the constants header.
 */
package burst_flash_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_BURST,
        ST_PROG
    } flash_state_t;

    typedef enum logic [1:0] {
        ACCEL_LOW  = 2'h0,
        ACCEL_NORM = 2'h1,
        ACCEL_HV   = 2'h2
    } accel_t;
endpackage : burst_flash_pkg

/* design/flash_cells.sv */
/*
 * Small array of flash words with registered read data.
 * Assumes one write port and one read port on the same clock.
 */
`timescale 1ns/1ps
module flash_cells #(
    parameter int AW = 8,
    parameter int DW = 16
) (
    input  wire logic          clk_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [DW-1:0] wdata_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic      [DW-1:0] rdata_o
);
    logic [DW-1:0] cells_r [0:(1<<AW)-1];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            cells_r[waddr_i] <= wdata_i;
        end
        rdata_o <= cells_r[raddr_i];
    end
endmodule : flash_cells

/* tb/flash_host_model.sv */
/*
 * Host memory controller model driving the burst flash pins.
 * Assumes the bench calls its tasks; pins change 1 ns after a clock rise.
 */
`timescale 1ns/1ps
module flash_host_model (
    input  wire logic        clk_i,
    output logic             fclk_o,
    output logic             address_valid_n_o,
    output logic             ce_n_o,
    output logic             oe_n_o,
    output logic             we_n_o,
    output logic             hw_rst_n_o,
    output logic             wp_n_o,
    output logic             burst_cfg_o,
    output logic [1:0]       accel_o,
    output logic [6:0]       a_hi_o,
    output logic [15:0]      adq_o
);
    initial begin
        fclk_o      = 1'b0;
        address_valid_n_o = 1'b1;
        ce_n_o      = 1'b1;
        oe_n_o      = 1'b1;
        we_n_o      = 1'b1;
        hw_rst_n_o  = 1'b1;
        wp_n_o      = 1'b1;
        burst_cfg_o = 1'b0;
        accel_o     = 2'h1;
        a_hi_o      = 7'h00;
        adq_o       = 16'h0000;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : hold
    task automatic put_addr(input logic [22:0] a, input logic edge_on);
        ce_n_o = 1'b0;
        {a_hi_o, adq_o} = a;
        hold(6);
        address_valid_n_o = 1'b0;
        hold(6);
        fclk_o = edge_on;
        hold(6);
        address_valid_n_o = 1'b1;
        fclk_o = 1'b0;
        adq_o = ~adq_o; // Released bus shows the inverse
        hold(6);
    endtask : put_addr
    task automatic prog(input logic [22:0] a, input logic [15:0] d, input logic wp,
                        input logic [1:0] lvl);
        wp_n_o = wp;
        accel_o = lvl;
        hold(6);
        put_addr(a, 1'b0);
        adq_o = d;
        hold(6);
        we_n_o = 1'b0;
    endtask : prog
    task automatic end_prog();
        we_n_o = 1'b1;
        adq_o = ~adq_o;
        ce_n_o = 1'b1;
        wp_n_o = 1'b1;
        accel_o = 2'h1;
        hold(50);
    endtask : end_prog
    task automatic async_read(input logic [22:0] a);
        put_addr(a, 1'b0);
        oe_n_o = 1'b0;
        hold(8);
    endtask : async_read
    task automatic end_access();
        oe_n_o = 1'b1;
        ce_n_o = 1'b1;
        hold(6);
    endtask : end_access
    task automatic burst_start(input logic [22:0] a);
        burst_cfg_o = 1'b1;
        oe_n_o = 1'b0;
        hold(6);
        put_addr(a, 1'b1);
    endtask : burst_start
    task automatic set_fclk(input logic v);
        fclk_o = v;
        hold(v ? 1 : 6);
    endtask : set_fclk
    task automatic hw_reset(input logic v);
        hw_rst_n_o = v;
        burst_cfg_o = 1'b0;
        hold(8);
    endtask : hw_reset
endmodule : flash_host_model

/* tb/burst_flash_pin_interface_tb.sv */
/*
 * Self-checking bench for the burst flash pin block with a host model.
 * Assumes default design parameters and a 20 MHz reference clock.
 */
`timescale 1ns/1ps
module burst_flash_pin_interface_tb;
    logic              ref_clk, rstn;
    wire logic         fclk, address_valid_n, ce_n, oe_n, we_n, hw_rst_n, wp_n, burst_cfg;
    wire logic [1:0]   accel;
    wire logic [6:0]   a_hi;
    wire logic [15:0]  adq_in, adq_out;
    wire logic         adq_oe, rdy, bypass, refused;
    logic [15:0]       exp_mem [256];
    logic [22:0]       a, b;
    int                num_errors, checks_done;

    flash_host_model u_flash_host_model (.clk_i(ref_clk), .fclk_o(fclk),
        .address_valid_n_o(address_valid_n),
        .ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n), .hw_rst_n_o(hw_rst_n), .wp_n_o(wp_n),
        .burst_cfg_o(burst_cfg), .accel_o(accel), .a_hi_o(a_hi), .adq_o(adq_in));
    burst_flash_pins u_burst_flash_pins (.REF_CLK_I(ref_clk), .RSTN_I(rstn), .FCLK_I(fclk),
        .ADDRESS_VALID_N_I(address_valid_n), .CE_N_I(ce_n), .OE_N_I(oe_n), .WE_N_I(we_n),
        .HW_RESET_N_I(hw_rst_n), .WP_N_I(wp_n), .BURST_CFG_I(burst_cfg),
        .PROGRAM_ACCEL_INPUT_I(accel), .A_HI_I(a_hi), .ADQ_I(adq_in), .ADQ_O(adq_out),
        .ADQ_OE_O(adq_oe), .RDY_O(rdy), .UNLOCK_BYPASS_O(bypass), .PROG_REFUSED_O(refused));

    always #25 ref_clk = ~ref_clk;

    function automatic logic is_refused(input logic [22:0] ad, input logic wp,
                                        input logic [1:0] lvl);
        return (lvl == 2'h0) || (!wp && (ad[22:14] == 9'h101 || ad[22:14] == 9'h102));
    endfunction : is_refused
    task automatic finish_test();
        $display("errors %0d, checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    task automatic check(input string what, input logic [15:0] e, input logic [15:0] s);
        checks_done++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, e, s);
        end
    endtask : check
    task automatic wait_rdy(input logic lvl);
        int n;
        n = 0;
        while (rdy !== lvl && n < 20) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (rdy !== lvl) begin
            num_errors++;
            $display("unexpected ready wait: expected %b, seen %b", lvl, rdy);
            finish_test();
        end
    endtask : wait_rdy
    task automatic do_prog(input logic [22:0] ad, input logic [15:0] d, input logic wp,
                           input logic [1:0] lvl);
        logic e;
        logic seen;
        e = is_refused(ad, wp, lvl);
        seen = 1'b0;
        u_flash_host_model.prog(ad, d, wp, lvl);
        repeat (12) begin
            @(posedge ref_clk);
            #1;
            if (refused === 1'b1) seen = 1'b1;
        end
        check("program refused", 16'(e), 16'(seen));
        check("unlock bypass", 16'(lvl == 2'h2), 16'(bypass));
        u_flash_host_model.end_prog();
        if (!e) exp_mem[ad[7:0]] = d;
    endtask : do_prog
    task automatic do_read(input logic [22:0] ad);
        u_flash_host_model.async_read(ad);
        check("read data", exp_mem[ad[7:0]], adq_out);
        check("read drive", 16'h0001, 16'(adq_oe));
        u_flash_host_model.end_access();
    endtask : do_read

    initial begin
        ref_clk = 1'b0;
        rstn = 1'b0;
        num_errors = 0;
        checks_done = 0;
        void'($urandom(32'hadd9af74));
        repeat (3) @(posedge ref_clk);
        #1 rstn = 1'b1;
        repeat (8) @(posedge ref_clk);
        #1;
        for (int i = 0; i < 6; i++) begin
            a = 23'($urandom());
            do_prog(a, 16'($urandom()), 1'b1, 2'h1);
            do_read(a);
        end
        // Protect boundary: sectors just outside and inside the pair
        for (int s = 256; s < 260; s++) begin
            a = {9'(s), 6'h00, 8'(8'h40 + s)};
            do_prog(a, 16'($urandom()), 1'b1, 2'h1);
            do_prog(a, 16'($urandom()), 1'b0, 2'h1);
            do_read(a);
        end
        b = {15'($urandom()), 8'h80};
        for (int i = 0; i < 4; i++) begin
            do_prog(b + 23'(i), 16'($urandom()), 1'b1, i[0] ? 2'h2 : 2'h1);
        end
        do_prog(b, 16'($urandom()), 1'b1, 2'h0);
        u_flash_host_model.burst_start(b);
        wait_rdy(1'b1);
        check("burst word", exp_mem[b[7:0]], adq_out);
        for (int k = 1; k < 4; k++) begin
            u_flash_host_model.set_fclk(1'b1);
            wait_rdy(1'b0);
            wait_rdy(1'b1);
            check("burst word", exp_mem[b[7:0] + 8'(k)], adq_out);
            u_flash_host_model.set_fclk(1'b0);
        end
        u_flash_host_model.hw_reset(1'b0);
        check("ready in reset", 16'h0000, 16'(rdy));
        check("drive in reset", 16'h0000, 16'(adq_oe));
        u_flash_host_model.hw_reset(1'b1);
        u_flash_host_model.end_access();
        do_read(b + 23'h2);
        finish_test();
    end
endmodule : burst_flash_pin_interface_tb
